// ==== core/dtg_defines.svh ====
`ifndef DTG_DEFINES_SVH
`define DTG_DEFINES_SVH

// System clock period in picoseconds (200 MHz)
`define DTG_CLK_PERIOD_PS   5000

// Nanosecond minimums, in picoseconds
`define DTG_ACT_TO_ACT_PS   7500
`define DTG_WRITE_REC_PS    15000
`define DTG_WR_TO_RD_PS     7500
`define DTG_RD_TO_PRE_PS    7500
`define DTG_SREF_EXTRA_PS   10000

// Cycle minimums, in link clock cycles
`define DTG_ACT_MIN_CK      2
`define DTG_COL_TO_COL_CK   2
`define DTG_CKE_PULSE_CK    3
`define DTG_SREF_RD_CK      200
`define DTG_PREPD_EXIT_CK   2
`define DTG_ACTPD_FAST_CK   2
`define DTG_SLOW_BASE_667   7
`define DTG_SLOW_BASE_800   8
`define DTG_TERM_TO_PD_CK   3
`define DTG_TERM_PDX_CK     8
`define DTG_MODE_SET_CK     2

// Mode register active power-down exit select bit, and auto-precharge address bit
`define DTG_MR_PDX_BIT      12
`define DTG_AP_BIT          10

// Command pin codes {ras_n, cas_n, we_n}
`define DTG_PIN_NOP         3'h7
`define DTG_PIN_ACT         3'h3
`define DTG_PIN_RD          3'h5
`define DTG_PIN_WR          3'h4
`define DTG_PIN_PRE         3'h2
`define DTG_PIN_REF         3'h1
`define DTG_PIN_MRS         3'h0

// Timer slots
`define DTG_TI_RRD          0
`define DTG_TI_CCD          1
`define DTG_TI_WTR          2
`define DTG_TI_MRD          3
`define DTG_TI_CKE          4
`define DTG_TI_XANY         5
`define DTG_TI_XRD          6
`define DTG_TI_ANPD         7
`define DTG_TI_AXPD         8
`define DTG_TI_ACT0         9
`define DTG_TI_PRE0         13
`define DTG_TI_NUM          17

`endif

// ==== core/dtg_pkg.sv ====
package dtg_pkg;

	typedef enum logic [3:0] {
		DTG_NOP,
		DTG_ACT,
		DTG_RD,
		DTG_WR,
		DTG_PRE,
		DTG_REF,
		DTG_MRS,
		DTG_SREF_IN,
		DTG_PD_IN,
		DTG_EXIT,
		DTG_ODT_ON,
		DTG_ODT_OFF
	} dtg_cmd_t;

	typedef enum logic [1:0] {
		PW_ON,
		PW_SELF,
		PW_PDPRE,
		PW_PDACT
	} dtg_pwr_t;

endpackage : dtg_pkg

// ==== core/dtg_timer.sv ====
`timescale 1ns/100ps

module dtg_timer #(
	parameter int W = 8
) (
	input  wire logic         CLK,
	input  wire logic         SRST,
	input  wire logic         TICK,
	input  wire logic         LOAD,
	input  wire logic [W-1:0] VALUE,
	output logic              ZERO
);

	logic [W-1:0] cnt_ff;

	// Load wins over the countdown; only the countdown waits for a link tick
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cnt_ff <= '0;
		end else if (LOAD) begin
			cnt_ff <= VALUE;
		end else if (TICK && (cnt_ff != '0)) begin
			cnt_ff <= cnt_ff - W'(1);
		end
	end

	assign ZERO = (cnt_ff == '0);

endmodule : dtg_timer

// ==== core/dtg_guard.sv ====
`timescale 1ns/100ps
`include "dtg_defines.svh"

// Summary of operation
// - Activates to different banks are spaced at least 7.5 ns.
// - Column commands are spaced at least 2 link cycles.
// - Write auto-precharge waits write recovery plus precharge before next activate.
// - Reads wait 7.5 ns after the internal end of write data.
// - Precharge waits 7.5 ns after a read to the same bank.
// - Clock enable holds each level at least 3 link cycles.
// - Self-refresh exit waits refresh cycle plus 10 ns before non-read commands.
// - Self-refresh exit waits 200 link cycles before a read.
// - Precharge power-down exit waits 2 link cycles before any command.
// - Active power-down exit: 2 cycles fast, 7-AL or 8-AL slow, before read.
// - Termination changes precede power-down entry by at least 3 cycles.
// - Termination changes wait 8 cycles after power-down exit.
// - Mode register set is followed by 2 cycles before next command.
// - Link clock keeps running after clock enable drops.
// - Mode register bit 12 selects fast or slow active power-down exit.
// - Activate spacing is never below two link cycles.
// - Read to precharge is at least AL plus half burst, and the 7.5 ns.
module dtg_guard
	import dtg_pkg::*;
#(
	parameter int CK_DIV    = 2,
	parameter int CL        = 5,
	parameter int AL        = 0,
	parameter int BL        = 4,
	parameter bit SPEED_800 = 1'b1,
	parameter int RFC_PS    = 75000,
	parameter int RP_PS     = 15000
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// Command request
	input  wire logic        REQ_VALID,
	input  wire dtg_cmd_t    REQ_CMD,
	input  wire logic [1:0]  REQ_BANK,
	input  wire logic [12:0] REQ_ADDR,
	output logic             REQ_READY,
	output logic             REQ_DONE,
	output logic             REQ_ERR,
	// Memory pins
	output logic             DDR_CK,
	output logic             DDR_CKE,
	output logic             DDR_CS_N,
	output logic             DDR_RAS_N,
	output logic             DDR_CAS_N,
	output logic             DDR_WE_N,
	output logic [1:0]       DDR_BA,
	output logic [12:0]      DDR_ADDR,
	output logic             DDR_ODT
);

	localparam int TCK_PS = `DTG_CLK_PERIOD_PS * CK_DIV;

	function automatic int ceil_ck(input int ps);
		int n;
		n = (ps + TCK_PS - 1) / TCK_PS;
		return (n < 1) ? 1 : n;
	endfunction : ceil_ck

	function automatic int imax(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : imax

	localparam int C_RRD   = imax(ceil_ck(`DTG_ACT_TO_ACT_PS), `DTG_ACT_MIN_CK);
	localparam int C_WR    = ceil_ck(`DTG_WRITE_REC_PS);
	localparam int C_RP    = ceil_ck(RP_PS);
	localparam int C_WL    = AL + CL - 1;
	localparam int C_BL2   = BL / 2;
	localparam int C_WTR   = C_WL + C_BL2 + ceil_ck(`DTG_WR_TO_RD_PS);
	localparam int C_RTP   = imax(AL + C_BL2, ceil_ck(`DTG_RD_TO_PRE_PS));
	localparam int C_RFC   = ceil_ck(RFC_PS);
	localparam int C_XSNR  = ceil_ck(RFC_PS + `DTG_SREF_EXTRA_PS);
	localparam int C_SLOWB = SPEED_800 ? `DTG_SLOW_BASE_800 : `DTG_SLOW_BASE_667;
	localparam int C_XARDS = imax(C_SLOWB - AL, 1);

	// Divider and tick
	logic [7:0] div_ff;
	logic [7:0] nxt_div;
	logic       tick;
	logic       ck_ff;

	// Held request
	logic        pend_ff;
	dtg_cmd_t    p_cmd_ff;
	logic [1:0]  p_bank_ff;
	logic [12:0] p_addr_ff;
	logic        rdy_ff;
	logic        done_ff;
	logic        err_ff;

	// Power and mode state
	dtg_pwr_t   pwr_ff;
	logic [3:0] open_ff;
	logic       slow_exit_ff;

	// Pin registers
	logic        cke_ff;
	logic        cs_n_ff;
	logic [2:0]  pins_ff;
	logic [1:0]  ba_ff;
	logic [12:0] addr_ff;
	logic        odt_ff;

	// Timers
	logic [`DTG_TI_NUM-1:0] tz;
	logic [`DTG_TI_NUM-1:0] ld_en;
	logic [7:0]             ld_val [`DTG_TI_NUM];

	logic state_ok;
	logic time_ok;
	logic issue;
	logic drop;
	logic take;
	logic ap;

	assign tick = (div_ff == 8'(CK_DIV - 1));
	assign nxt_div = tick ? 8'h00 : div_ff + 8'h01;
	assign ap = p_addr_ff[`DTG_AP_BIT];

	// Free-running link clock; commands change on its falling edge
	always_ff @(posedge CLK) begin
		if (SRST) begin
			div_ff <= 8'h00;
			ck_ff  <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			ck_ff  <= (nxt_div >= 8'(CK_DIV / 2));
		end
	end

	generate
		for (genvar gi = 0; gi < `DTG_TI_NUM; gi++) begin : g_tim
			dtg_timer #(.W(8)) u_tim (
				.CLK   (CLK),
				.SRST  (SRST),
				.TICK  (tick),
				.LOAD  (ld_en[gi]),
				.VALUE (ld_val[gi]),
				.ZERO  (tz[gi])
			);
		end
	endgenerate

	always_comb begin
		if (pwr_ff == PW_ON) begin
			state_ok = (p_cmd_ff != DTG_EXIT);
		end else begin
			state_ok = (p_cmd_ff inside {DTG_EXIT, DTG_NOP, DTG_ODT_ON, DTG_ODT_OFF});
		end
	end

	always_comb begin
		case (p_cmd_ff)
			DTG_ACT:     time_ok = tz[`DTG_TI_XANY] && tz[`DTG_TI_MRD] && tz[`DTG_TI_RRD]
			                       && tz[`DTG_TI_ACT0 + p_bank_ff];
			DTG_RD:      time_ok = tz[`DTG_TI_XRD] && tz[`DTG_TI_MRD] && tz[`DTG_TI_CCD]
			                       && tz[`DTG_TI_WTR];
			DTG_WR:      time_ok = tz[`DTG_TI_XANY] && tz[`DTG_TI_MRD] && tz[`DTG_TI_CCD];
			DTG_PRE:     time_ok = tz[`DTG_TI_XANY] && tz[`DTG_TI_MRD]
			                       && (ap ? (&tz[`DTG_TI_PRE0 +: 4])
			                              : tz[`DTG_TI_PRE0 + p_bank_ff]);
			DTG_REF,
			DTG_MRS:     time_ok = tz[`DTG_TI_XANY] && tz[`DTG_TI_MRD];
			DTG_SREF_IN,
			DTG_PD_IN:   time_ok = tz[`DTG_TI_XANY] && tz[`DTG_TI_MRD] && tz[`DTG_TI_CKE]
			                       && tz[`DTG_TI_ANPD];
			DTG_EXIT:    time_ok = tz[`DTG_TI_CKE];
			DTG_ODT_ON,
			DTG_ODT_OFF: time_ok = tz[`DTG_TI_AXPD];
			default:     time_ok = 1'b1;
		endcase
	end

	assign issue = tick && pend_ff && state_ok && time_ok;
	assign drop  = tick && pend_ff && !state_ok;
	assign take  = REQ_VALID && rdy_ff;

	// Timer loads for the command being issued
	always_comb begin
		ld_en = '0;
		for (int i = 0; i < `DTG_TI_NUM; i++) begin
			ld_val[i] = 8'h00;
		end
		if (issue) begin
			case (p_cmd_ff)
				DTG_ACT: begin
					ld_en[`DTG_TI_RRD]  = 1'b1;
					ld_val[`DTG_TI_RRD] = 8'(C_RRD);
				end
				DTG_RD: begin
					ld_en[`DTG_TI_CCD]              = 1'b1;
					ld_val[`DTG_TI_CCD]             = 8'(`DTG_COL_TO_COL_CK);
					ld_en[`DTG_TI_PRE0 + p_bank_ff]  = 1'b1;
					ld_val[`DTG_TI_PRE0 + p_bank_ff] = 8'(C_RTP);
					if (ap) begin
						ld_en[`DTG_TI_ACT0 + p_bank_ff]  = 1'b1;
						ld_val[`DTG_TI_ACT0 + p_bank_ff] = 8'(C_RTP + C_RP);
					end
				end
				DTG_WR: begin
					ld_en[`DTG_TI_CCD]              = 1'b1;
					ld_val[`DTG_TI_CCD]             = 8'(`DTG_COL_TO_COL_CK);
					ld_en[`DTG_TI_WTR]              = 1'b1;
					ld_val[`DTG_TI_WTR]             = 8'(C_WTR);
					ld_en[`DTG_TI_PRE0 + p_bank_ff]  = 1'b1;
					ld_val[`DTG_TI_PRE0 + p_bank_ff] = 8'(C_WL + C_BL2 + C_WR);
					if (ap) begin
						ld_en[`DTG_TI_ACT0 + p_bank_ff]  = 1'b1;
						ld_val[`DTG_TI_ACT0 + p_bank_ff] = 8'(C_WL + C_BL2 + C_WR + C_RP);
					end
				end
				DTG_REF: begin
					ld_en[`DTG_TI_XANY]  = 1'b1;
					ld_val[`DTG_TI_XANY] = 8'(C_RFC);
				end
				DTG_MRS: begin
					ld_en[`DTG_TI_MRD]  = 1'b1;
					ld_val[`DTG_TI_MRD] = 8'(`DTG_MODE_SET_CK);
				end
				DTG_SREF_IN,
				DTG_PD_IN: begin
					ld_en[`DTG_TI_CKE]  = 1'b1;
					ld_val[`DTG_TI_CKE] = 8'(`DTG_CKE_PULSE_CK);
				end
				DTG_EXIT: begin
					ld_en[`DTG_TI_CKE]   = 1'b1;
					ld_val[`DTG_TI_CKE]  = 8'(`DTG_CKE_PULSE_CK);
					ld_en[`DTG_TI_AXPD]  = 1'b1;
					ld_val[`DTG_TI_AXPD] = 8'(`DTG_TERM_PDX_CK);
					ld_en[`DTG_TI_XANY]  = 1'b1;
					ld_en[`DTG_TI_XRD]   = 1'b1;
					if (pwr_ff == PW_SELF) begin
						ld_val[`DTG_TI_XANY] = 8'(C_XSNR);
						ld_val[`DTG_TI_XRD]  = 8'(`DTG_SREF_RD_CK);
					end else if (pwr_ff == PW_PDACT) begin
						ld_val[`DTG_TI_XANY] = 8'(`DTG_PREPD_EXIT_CK);
						ld_val[`DTG_TI_XRD]  = slow_exit_ff ? 8'(C_XARDS)
						                                    : 8'(`DTG_ACTPD_FAST_CK);
					end else begin
						ld_val[`DTG_TI_XANY] = 8'(`DTG_PREPD_EXIT_CK);
						ld_val[`DTG_TI_XRD]  = 8'(`DTG_PREPD_EXIT_CK);
					end
				end
				DTG_ODT_ON,
				DTG_ODT_OFF: begin
					ld_en[`DTG_TI_ANPD]  = 1'b1;
					ld_val[`DTG_TI_ANPD] = 8'(`DTG_TERM_TO_PD_CK);
				end
				default: begin
				end
			endcase
		end
	end

	// One held request; ready mirrors the empty slot
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pend_ff   <= 1'b0;
			rdy_ff    <= 1'b1;
			p_cmd_ff  <= DTG_NOP;
			p_bank_ff <= 2'h0;
			p_addr_ff <= 13'h0000;
			done_ff   <= 1'b0;
			err_ff    <= 1'b0;
		end else begin
			done_ff <= issue;
			err_ff  <= drop;
			if (issue || drop) begin
				pend_ff <= 1'b0;
				rdy_ff  <= 1'b1;
			end else if (take) begin
				pend_ff   <= 1'b1;
				rdy_ff    <= 1'b0;
				p_cmd_ff  <= REQ_CMD;
				p_bank_ff <= REQ_BANK;
				p_addr_ff <= REQ_ADDR;
			end
		end
	end

	// Power state, open banks and exit mode
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pwr_ff       <= PW_ON;
			open_ff      <= 4'h0;
			slow_exit_ff <= 1'b0;
		end else if (issue) begin
			case (p_cmd_ff)
				DTG_ACT:     open_ff[p_bank_ff] <= 1'b1;
				DTG_RD,
				DTG_WR:      if (ap) open_ff[p_bank_ff] <= 1'b0;
				DTG_PRE:     if (ap) open_ff <= 4'h0; else open_ff[p_bank_ff] <= 1'b0;
				DTG_MRS:     if (p_bank_ff == 2'h0) slow_exit_ff <= p_addr_ff[`DTG_MR_PDX_BIT];
				DTG_SREF_IN: pwr_ff <= PW_SELF;
				DTG_PD_IN:   pwr_ff <= (open_ff != 4'h0) ? PW_PDACT : PW_PDPRE;
				DTG_EXIT:    pwr_ff <= PW_ON;
				default:     pwr_ff <= pwr_ff;
			endcase
		end
	end

	// Pins: NOP unless a command goes out this link cycle
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cke_ff  <= 1'b1;
			cs_n_ff <= 1'b1;
			pins_ff <= `DTG_PIN_NOP;
			ba_ff   <= 2'h0;
			addr_ff <= 13'h0000;
			odt_ff  <= 1'b0;
		end else if (tick) begin
			cs_n_ff <= !issue;
			pins_ff <= `DTG_PIN_NOP;
			if (issue) begin
				ba_ff   <= p_bank_ff;
				addr_ff <= p_addr_ff;
				case (p_cmd_ff)
					DTG_ACT:     pins_ff <= `DTG_PIN_ACT;
					DTG_RD:      pins_ff <= `DTG_PIN_RD;
					DTG_WR:      pins_ff <= `DTG_PIN_WR;
					DTG_PRE:     pins_ff <= `DTG_PIN_PRE;
					DTG_REF:     pins_ff <= `DTG_PIN_REF;
					DTG_MRS:     pins_ff <= `DTG_PIN_MRS;
					DTG_SREF_IN: begin
						pins_ff <= `DTG_PIN_REF;
						cke_ff  <= 1'b0;
					end
					DTG_PD_IN:   cke_ff <= 1'b0;
					DTG_EXIT:    cke_ff <= 1'b1;
					DTG_ODT_ON:  odt_ff <= 1'b1;
					DTG_ODT_OFF: odt_ff <= 1'b0;
					default:     pins_ff <= `DTG_PIN_NOP;
				endcase
			end
		end
	end

	assign REQ_READY = rdy_ff;
	assign REQ_DONE  = done_ff;
	assign REQ_ERR   = err_ff;
	assign DDR_CK    = ck_ff;
	assign DDR_CKE   = cke_ff;
	assign DDR_CS_N  = cs_n_ff;
	assign DDR_RAS_N = pins_ff[2];
	assign DDR_CAS_N = pins_ff[1];
	assign DDR_WE_N  = pins_ff[0];
	assign DDR_BA    = ba_ff;
	assign DDR_ADDR  = addr_ff;
	assign DDR_ODT   = odt_ff;

endmodule : dtg_guard

// ==== test/dtg_guard_monitor.sv ====
`timescale 1ns/100ps

module dtg_guard_monitor #(
	parameter int CK_DIV = 2,
	parameter int CL     = 5,
	parameter int AL     = 0,
	parameter int BL     = 4
) (
	// Clock and reset
	input wire logic        CLK,
	input wire logic        SRST,
	// Handshake
	input wire logic        REQ_DONE,
	// Memory pins
	input wire logic        DDR_CKE,
	input wire logic        DDR_CS_N,
	input wire logic        DDR_RAS_N,
	input wire logic        DDR_CAS_N,
	input wire logic        DDR_WE_N,
	input wire logic [1:0]  DDR_BA,
	input wire logic [12:0] DDR_ADDR,
	input wire logic        DDR_ODT
);
	localparam int WTR_C = CK_DIV * (AL + CL - 1 + BL / 2 + 1);
	localparam int RTP_C = CK_DIV * (AL + BL / 2);
	logic [2:0] code;
	logic       iss;
	logic       act;
	logic       col;
	logic       rd;
	logic       pre;
	logic       mrs;
	logic [7:0] wr_cnt_ff;
	logic [7:0] rd_cnt_ff;
	logic [1:0] rd_bank_ff;

	assign code = {DDR_RAS_N, DDR_CAS_N, DDR_WE_N};
	assign iss  = REQ_DONE && !DDR_CS_N;
	assign act  = iss && code == 3'h3;
	assign rd   = iss && code == 3'h5;
	assign col  = rd || (iss && code == 3'h4);
	assign pre  = iss && code == 3'h2;
	assign mrs  = iss && code == 3'h0;

	// Counters saturate so a long idle stretch never wraps into a false hit
	always_ff @(posedge CLK) begin
		if (SRST)
			wr_cnt_ff <= 8'hFF;
		else if (iss && code == 3'h4)
			wr_cnt_ff <= 8'h01;
		else if (wr_cnt_ff != 8'hFF)
			wr_cnt_ff <= wr_cnt_ff + 8'h01;
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rd_cnt_ff  <= 8'hFF;
			rd_bank_ff <= 2'h0;
		end else if (rd) begin
			rd_cnt_ff  <= 8'h01;
			rd_bank_ff <= DDR_BA;
		end else if (rd_cnt_ff != 8'hFF)
			rd_cnt_ff <= rd_cnt_ff + 8'h01;
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	chk_act_space: assert property (act |=> !act [*3])
		else $error("activate spacing too short");
	chk_col_space: assert property (col |=> !col [*3])
		else $error("column spacing too short");
	chk_mode_space: assert property (mrs |=> !iss [*3])
		else $error("command too soon after mode set");
	chk_cke_hold: assert property ($changed(DDR_CKE) |=> $stable(DDR_CKE) [*5])
		else $error("clock enable pulse too short");
	chk_wr_rd: assert property (rd |-> wr_cnt_ff >= WTR_C)
		else $error("read too soon after write");
	chk_rd_pre: assert property (pre && (DDR_ADDR[10] || DDR_BA == rd_bank_ff) |-> rd_cnt_ff >= RTP_C)
		else $error("precharge too soon after read");
	chk_pd_exit: assert property ($rose(DDR_CKE) |=> !iss [*3])
		else $error("command too soon after power-down exit");
	chk_odt_pd: assert property ($changed(DDR_ODT) |=> $stable(DDR_CKE) [*5])
		else $error("power-down too soon after termination change");
	chk_pdx_odt: assert property ($rose(DDR_CKE) |=> $stable(DDR_ODT) [*8])
		else $error("termination change too soon after exit");
endmodule : dtg_guard_monitor

bind dtg_guard dtg_guard_monitor #(.CK_DIV(CK_DIV), .CL(CL), .AL(AL), .BL(BL)) u_mon (
	.CLK, .SRST, .REQ_DONE, .DDR_CKE, .DDR_CS_N, .DDR_RAS_N, .DDR_CAS_N, .DDR_WE_N,
	.DDR_BA, .DDR_ADDR, .DDR_ODT);

// ==== test/dtg_dev_model.sv ====
`timescale 1ns/100ps

module dtg_dev_model (
	// Link pins
	input  wire logic        ck,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [1:0]  ba,
	input  wire logic [12:0] addr,
	// Device state seen by the bench
	output logic             mr_slow,
	output logic             diff_strobe,
	output logic             drive_on,
	output int               n_act
);
	logic [2:0] code;
	logic       sel;

	assign code = {ras_n, cas_n, we_n};
	// Commands only count while clock enable is sampled high
	assign sel  = cke && !cs_n;

	initial begin
		mr_slow     = 1'b0;
		diff_strobe = 1'b1;
		drive_on    = 1'b0;
		n_act       = 0;
	end

	always @(posedge ck) begin
		if (sel && code == 3'h3)
			n_act <= n_act + 1;
		if (sel && code == 3'h0 && ba == 2'h0)
			mr_slow <= addr[12];
		if (sel && code == 3'h0 && ba == 2'h1) begin
			diff_strobe <= !addr[10];
			// Drive output appears at once, the earliest end of its window
			drive_on <= addr[9:7] == 3'h1 || addr[9:7] == 3'h2;
		end
	end
endmodule : dtg_dev_model

// ==== test/tb.sv ====
`timescale 1ns/100ps

module tb;
	import dtg_pkg::*;
	logic        CLK;
	logic        SRST;
	logic        REQ_VALID;
	dtg_cmd_t    REQ_CMD;
	logic [1:0]  REQ_BANK;
	logic [12:0] REQ_ADDR;
	logic        REQ_READY, REQ_DONE, REQ_ERR;
	logic        DDR_CK, DDR_CKE, DDR_CS_N, DDR_RAS_N, DDR_CAS_N, DDR_WE_N, DDR_ODT;
	logic [1:0]  DDR_BA;
	logic [12:0] DDR_ADDR;
	logic        mr_slow, diff_strobe, drive_on;
	int          n_act;
	int          fails = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          t_now, t_ref;
	logic        err_now;

	dtg_guard #(.CK_DIV(2), .CL(5), .AL(0), .BL(4)) DUT (
		.CLK, .SRST, .REQ_VALID, .REQ_CMD, .REQ_BANK, .REQ_ADDR, .REQ_READY, .REQ_DONE,
		.REQ_ERR, .DDR_CK, .DDR_CKE, .DDR_CS_N, .DDR_RAS_N, .DDR_CAS_N, .DDR_WE_N,
		.DDR_BA, .DDR_ADDR, .DDR_ODT);

	dtg_dev_model u_dev (
		.ck(DDR_CK), .cke(DDR_CKE), .cs_n(DDR_CS_N), .ras_n(DDR_RAS_N), .cas_n(DDR_CAS_N),
		.we_n(DDR_WE_N), .ba(DDR_BA), .addr(DDR_ADDR), .mr_slow(mr_slow),
		.diff_strobe(diff_strobe), .drive_on(drive_on), .n_act(n_act));

	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	always @(posedge CLK) cyc <= cyc + 1;

	task automatic finish_test;
		$display("checks %0d failures %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
		end
	endtask : check

	// Issue spacing: at least lo, and no more than the bench's own turnaround beyond it
	task automatic gap(input string what, input int lo);
		int d;
		d = t_now - t_ref;
		check(what, (d >= lo && d <= lo + 8) ? lo : d, lo);
	endtask : gap

	// Entered just after a rising edge; returns on the edge ending the answer cycle
	task automatic cmd(input dtg_cmd_t c, input logic [1:0] b, input logic [12:0] a);
		int i;
		REQ_VALID <= 1'b1;
		REQ_CMD   <= c;
		REQ_BANK  <= b;
		REQ_ADDR  <= a;
		for (i = 0; i < 1000; i++) begin
			@(negedge CLK);
			if (REQ_READY === 1'b1)
				break;
		end
		// A slot that never empties is a hang, not a pass
		if (i == 1000) begin
			fails++;
			finish_test();
		end
		@(posedge CLK);
		REQ_VALID <= 1'b0;
		for (i = 0; i < 1000; i++) begin
			@(negedge CLK);
			if (REQ_DONE === 1'b1 || REQ_ERR === 1'b1)
				break;
		end
		if (i == 1000) begin
			fails++;
			finish_test();
		end
		t_now   = cyc;
		err_now = REQ_ERR;
		@(posedge CLK);
	endtask : cmd

	task automatic t_mode;
		cmd(DTG_MRS, 2'h0, 13'h1000);
		cmd(DTG_MRS, 2'h1, 13'h0480);
		t_ref = t_now;
		cmd(DTG_ACT, 2'h0, 13'h0010);
		gap("mrs_to_act", 4);
		check("slow_exit", mr_slow, 1'b1);
		check("strobe_diff", diff_strobe, 1'b0);
		check("drive_mode", drive_on, 1'b1);
	endtask : t_mode

	task automatic t_act_col;
		t_ref = t_now;
		cmd(DTG_ACT, 2'h1, 13'h0020);
		gap("act_to_act", 4);
		cmd(DTG_WR, 2'h0, 13'h0000);
		t_ref = t_now;
		cmd(DTG_RD, 2'h0, 13'h0000);
		gap("wr_to_rd", 14);
		t_ref = t_now;
		cmd(DTG_RD, 2'h0, 13'h0004);
		gap("rd_to_rd", 4);
		t_ref = t_now;
		cmd(DTG_PRE, 2'h0, 13'h0000);
		gap("rd_to_pre", 4);
		cmd(DTG_ACT, 2'h0, 13'h0030);
		cmd(DTG_WR, 2'h0, 13'h0400);
		t_ref = t_now;
		cmd(DTG_ACT, 2'h0, 13'h0040);
		gap("wrap_to_act", 20);
	endtask : t_act_col

	task automatic t_act_pd;
		cmd(DTG_ODT_ON, 2'h0, 13'h0000);
		check("odt_on", DDR_ODT, 1'b1);
		t_ref = t_now;
		cmd(DTG_PD_IN, 2'h0, 13'h0000);
		gap("odt_to_pd", 6);
		check("cke_low", DDR_CKE, 1'b0);
		t_ref = t_now;
		cmd(DTG_RD, 2'h1, 13'h0000);
		check("rd_refused", err_now, 1'b1);
		cmd(DTG_EXIT, 2'h0, 13'h0000);
		gap("cke_low_hold", 6);
		t_ref = t_now;
		// Read goes first so the slow exit wait is the only thing holding it
		cmd(DTG_RD, 2'h1, 13'h0000);
		gap("slow_pdx_to_rd", 16);
		cmd(DTG_ODT_OFF, 2'h0, 13'h0000);
		gap("pdx_to_odt", 16);
	endtask : t_act_pd

	task automatic t_pre_pd;
		cmd(DTG_PRE, 2'h0, 13'h0400);
		cmd(DTG_PD_IN, 2'h0, 13'h0000);
		cmd(DTG_EXIT, 2'h0, 13'h0000);
		t_ref = t_now;
		cmd(DTG_ACT, 2'h2, 13'h0050);
		gap("pdx_to_act", 4);
		// Activate is early, so only the exit latency holds the termination change
		cmd(DTG_ODT_ON, 2'h0, 13'h0000);
		gap("pdx_to_odt_pre", 16);
	endtask : t_pre_pd

	task automatic t_sref;
		cmd(DTG_EXIT, 2'h0, 13'h0000);
		check("exit_refused", err_now, 1'b1);
		cmd(DTG_PRE, 2'h0, 13'h0400);
		cmd(DTG_SREF_IN, 2'h0, 13'h0000);
		cmd(DTG_EXIT, 2'h0, 13'h0000);
		t_ref = t_now;
		cmd(DTG_ACT, 2'h3, 13'h0060);
		gap("srx_to_act", 18);
		cmd(DTG_RD, 2'h3, 13'h0000);
		gap("srx_to_rd", 400);
		check("act_count", n_act, 6);
	endtask : t_sref

	initial begin
		SRST      = 1'b1;
		REQ_VALID = 1'b0;
		REQ_CMD   = DTG_NOP;
		REQ_BANK  = 2'h0;
		REQ_ADDR  = 13'h0000;
		repeat (6) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		check("cke_rst", DDR_CKE, 1'b1);
		check("cs_rst", DDR_CS_N, 1'b1);
		check("odt_rst", DDR_ODT, 1'b0);
		t_mode();
		t_act_col();
		t_act_pd();
		t_pre_pd();
		t_sref();
		finish_test();
	end
endmodule : tb
